// file: core/pif_pkg.sv
// package for the peripheral interrupt flag block
package pif_pkg;
    localparam logic [11:0] PIF_ENABLE_OFF = 12'h000;
    localparam logic [11:0] PIF_REQUEST_OFF = 12'h004;
    localparam logic [11:0] PIF_CONTROL_OFF = 12'h008;
    localparam logic [11:0] PIF_POWER_OFF = 12'h00c;
    localparam logic [7:0] PIF_ENABLE_RST = 8'h00;
    localparam logic [7:0] PIF_REQUEST_RST = 8'h00;
    localparam logic [1:0] PIF_CONTROL_RST = 2'h0;
    // power control reset value: ulp wake off, soft brownout on, power-on 0, brownout 0
    localparam logic [7:0] PIF_POWER_RST = 8'h10;
    localparam int PIF_EEPROM_BIT = 7;
    localparam int PIF_ADC_BIT = 6;
    localparam int PIF_CAPCMP_BIT = 5;
    localparam int PIF_CMP_B_BIT = 4;
    localparam int PIF_CMP_A_BIT = 3;
    localparam int PIF_OSC_BIT = 2;
    localparam int PIF_PERIOD_BIT = 1;
    localparam int PIF_OVF_BIT = 0;
    localparam int PIF_GLOBAL_BIT = 1;
    localparam int PIF_GROUP_BIT = 0;
    localparam int PIF_ULPWU_BIT = 5;
    localparam int PIF_SOFT_BROWNOUT_BIT = 4;
    localparam int PIF_WATCHDOG_BIT = 3;
    localparam int PIF_PIN_BIT = 2;
    localparam int PIF_POR_BIT = 1;
    localparam int PIF_BROWNOUT_BIT = 0;
    localparam logic [7:0] PIF_POWER_WMASK = 8'h3f;
    typedef enum logic [1:0] {
        PIF_MODE_OFF = 2'h0,
        PIF_MODE_CAPTURE = 2'h1,
        PIF_MODE_COMPARE = 2'h3,
        PIF_MODE_PWM = 2'h2
    } pif_ccp_mode_t;
    typedef struct packed {
        logic eeprom_done;
        logic adc_done;
        logic capture;
        logic compare_match;
        logic comparator_b;
        logic comparator_a;
        logic osc_fail;
        logic period_match;
        logic counter_overflow;
    } pif_events_t;
    typedef struct packed {
        logic brownout;
        logic watchdog;
        logic pin;
    } pif_causes_t;
endpackage

// file: core/pif_top.sv
// peripheral interrupt enable, request flags, control and power status over apb
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pif_top
    import pif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pif_events_t events,
    input wire pif_ccp_mode_t ccp_mode,
    input wire pif_causes_t causes,
    output logic periph_irq,
    output logic ulp_wake_enable,
    output logic soft_brownout_enable
);
    logic [7:0] enable_q;
    logic [7:0] request_q;
    logic [1:0] control_q;
    logic [7:0] power_q;
    logic [7:0] set_vec;
    logic wr_en;
    logic rd_en;
    logic irq_d;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    assign wr_en = psel && penable && pwrite && !pready;
    assign rd_en = psel && penable && !pwrite && !pready;

    // capture only in capture mode, match only in compare mode
    always_comb
    begin
        set_vec = 8'h00;
        set_vec[PIF_EEPROM_BIT] = events.eeprom_done;
        set_vec[PIF_ADC_BIT] = events.adc_done;
        set_vec[PIF_CAPCMP_BIT] = (ccp_mode == PIF_MODE_CAPTURE && events.capture)
            || (ccp_mode == PIF_MODE_COMPARE && events.compare_match);
        set_vec[PIF_CMP_B_BIT] = events.comparator_b;
        set_vec[PIF_CMP_A_BIT] = events.comparator_a;
        set_vec[PIF_OSC_BIT] = events.osc_fail;
        set_vec[PIF_PERIOD_BIT] = events.period_match;
        set_vec[PIF_OVF_BIT] = events.counter_overflow;
    end

    // one-wait-state apb answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pslverr <= !(hit(paddr, PIF_ENABLE_OFF) || hit(paddr, PIF_REQUEST_OFF)
                || hit(paddr, PIF_CONTROL_OFF) || hit(paddr, PIF_POWER_OFF));
        end
        else
        begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            if (hit(paddr, PIF_ENABLE_OFF))
            begin
                prdata <= {24'h000000, enable_q};
            end
            else if (hit(paddr, PIF_REQUEST_OFF))
            begin
                prdata <= {24'h000000, request_q};
            end
            else if (hit(paddr, PIF_CONTROL_OFF))
            begin
                prdata <= {30'h0000_0000, control_q};
            end
            else if (hit(paddr, PIF_POWER_OFF))
            begin
                prdata <= {24'h000000, power_q};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
        else
        begin
            prdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= PIF_ENABLE_RST;
        end
        else if (wr_en && pstrb[0] && hit(paddr, PIF_ENABLE_OFF))
        begin
            enable_q <= pwdata[7:0];
        end
    end

    // flags set from events ignoring enables; a set beats a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            request_q <= PIF_REQUEST_RST;
        end
        else if (wr_en && pstrb[0] && hit(paddr, PIF_REQUEST_OFF))
        begin
            request_q <= pwdata[7:0] | set_vec;
        end
        else
        begin
            request_q <= request_q | set_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_q <= PIF_CONTROL_RST;
        end
        else if (wr_en && pstrb[0] && hit(paddr, PIF_CONTROL_OFF))
        begin
            control_q <= pwdata[1:0];
        end
    end

    // power status and controls; causes win over software writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_q <= PIF_POWER_RST;
        end
        else
        begin
            if (wr_en && pstrb[0] && hit(paddr, PIF_POWER_OFF))
            begin
                power_q <= pwdata[7:0] & PIF_POWER_WMASK;
            end
            // cause flags are active low like the por bit
            if (causes.brownout)
            begin
                power_q[PIF_BROWNOUT_BIT] <= 1'b0;
            end
            if (causes.watchdog)
            begin
                power_q[PIF_WATCHDOG_BIT] <= 1'b0;
            end
            if (causes.pin)
            begin
                power_q[PIF_PIN_BIT] <= 1'b0;
            end
        end
    end

    assign ulp_wake_enable = power_q[PIF_ULPWU_BIT];
    assign soft_brownout_enable = power_q[PIF_SOFT_BROWNOUT_BIT];

    // group and global gating of the masked flags
    assign irq_d = control_q[PIF_GLOBAL_BIT] && control_q[PIF_GROUP_BIT]
        && |(request_q & enable_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_irq <= 1'b0;
        end
        else
        begin
            periph_irq <= irq_d;
        end
    end

    group_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(control_q[PIF_GROUP_BIT]) |-> !periph_irq)
        else $error("irq without group enable");

    // request follows gated flags one cycle later
    irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 periph_irq == $past(control_q[PIF_GLOBAL_BIT] && control_q[PIF_GROUP_BIT]
        && (request_q & enable_q) != 8'h00))
        else $error("irq does not follow flags");

    enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == PIF_ENABLE_OFF) |=> enable_q == $past(pwdata[7:0]))
        else $error("enable write lost");

    // event sets flag even with enables off
    flag_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_vec[PIF_OVF_BIT] |=> request_q[PIF_OVF_BIT])
        else $error("overflow flag not set");

    eeprom_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.eeprom_done |=> request_q[PIF_EEPROM_BIT])
        else $error("eeprom flag not set");

    adc_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.adc_done |=> request_q[PIF_ADC_BIT])
        else $error("adc flag not set");

    // pwm mode never sets capture flag
    pwm_unused_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ccp_mode == PIF_MODE_PWM && !request_q[PIF_CAPCMP_BIT] && !wr_en)
        |=> !request_q[PIF_CAPCMP_BIT])
        else $error("capcmp flag set in pwm mode");

    compare_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ccp_mode == PIF_MODE_COMPARE && events.compare_match)
        |=> request_q[PIF_CAPCMP_BIT])
        else $error("compare flag not set");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_PERIOD_BIT] && !wr_en) |=> request_q[PIF_PERIOD_BIT])
        else $error("period flag dropped");

    // power-on bit low after reset until written
    por_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!power_q[PIF_POR_BIT] && !wr_en) |=> !power_q[PIF_POR_BIT])
        else $error("por bit set by hardware");

    global_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !control_q[PIF_GLOBAL_BIT] |=> !periph_irq)
        else $error("irq without global enable");

    strobe_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && !pstrb[0]) |=> $stable(enable_q))
        else $error("enable written without strobe");

    // event in the clearing cycle still sets
    set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == PIF_REQUEST_OFF)
        |=> (request_q & $past(set_vec)) == $past(set_vec))
        else $error("event lost under clear");

    // capture sets flag in capture mode
    capture_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ccp_mode == PIF_MODE_CAPTURE && events.capture)
        |=> request_q[PIF_CAPCMP_BIT])
        else $error("capture flag not set");

    // match flag held until software write
    capcmp_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_CAPCMP_BIT] && !wr_en) |=> request_q[PIF_CAPCMP_BIT])
        else $error("capcmp flag dropped");

    cmp_b_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.comparator_b |=> request_q[PIF_CMP_B_BIT])
        else $error("comparator b flag not set");

    cmp_b_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_CMP_B_BIT] && !wr_en) |=> request_q[PIF_CMP_B_BIT])
        else $error("comparator b flag dropped");

    cmp_a_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.comparator_a |=> request_q[PIF_CMP_A_BIT])
        else $error("comparator a flag not set");

    cmp_a_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_CMP_A_BIT] && !wr_en) |=> request_q[PIF_CMP_A_BIT])
        else $error("comparator a flag dropped");

    osc_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.osc_fail |=> request_q[PIF_OSC_BIT])
        else $error("oscillator flag not set");

    osc_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_OSC_BIT] && !wr_en) |=> request_q[PIF_OSC_BIT])
        else $error("oscillator flag dropped");

    period_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.period_match |=> request_q[PIF_PERIOD_BIT])
        else $error("period flag not set");

    overflow_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_OVF_BIT] && !wr_en) |=> request_q[PIF_OVF_BIT])
        else $error("overflow flag dropped");

    eeprom_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (request_q[PIF_EEPROM_BIT] && !wr_en) |=> request_q[PIF_EEPROM_BIT])
        else $error("eeprom flag dropped");

    brownout_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        causes.brownout |=> !power_q[PIF_BROWNOUT_BIT])
        else $error("brownout cause not shown");

    watchdog_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        causes.watchdog |=> !power_q[PIF_WATCHDOG_BIT])
        else $error("watchdog cause not shown");

    pin_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        causes.pin |=> !power_q[PIF_PIN_BIT])
        else $error("pin cause not shown");

    power_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == PIF_POWER_OFF) |=> ulp_wake_enable
        == $past(pwdata[PIF_ULPWU_BIT]) && soft_brownout_enable == $past(pwdata[PIF_SOFT_BROWNOUT_BIT]))
        else $error("power controls not written");
endmodule // pif_top
`default_nettype wire

// file: testbench/pif_far.sv
// far-side model: peripheral event sources and reset causes
`timescale 1ns/1ns
`default_nettype none
module pif_far
    import pif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [8:0] fire,
    input wire logic [2:0] cause_fire,
    output var pif_events_t events,
    output var pif_causes_t causes
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            events <= '0;
            causes <= '0;
        end
        else
        begin
            events <= fire;
            causes <= cause_fire;
        end
    end
endmodule // pif_far
`default_nettype wire

// file: testbench/tb_pif_top.sv
// self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ns
`default_nettype none
module tb_pif_top;
    import pif_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic periph_irq, ulp_wake_enable, soft_brownout_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [8:0] fire;
    logic [2:0] cause_fire, c;
    logic [7:0] v;
    pif_events_t events;
    pif_causes_t causes;
    pif_ccp_mode_t ccp_mode;
    int n_errors, n_compared, cyc;
    pif_top i_pif_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .ccp_mode(ccp_mode),
        .causes(causes), .periph_irq(periph_irq), .ulp_wake_enable(ulp_wake_enable),
        .soft_brownout_enable(soft_brownout_enable));
    pif_far i_pif_far (.pclk(pclk), .presetn(presetn), .fire(fire),
        .cause_fire(cause_fire), .events(events), .causes(causes));
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pulse(input logic [8:0] f, input logic [2:0] cs);
        fire <= f;
        cause_fire <= cs;
        @(posedge pclk);
        fire <= '0;
        cause_fire <= '0;
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic [7:0] flag_of(input int k, input pif_ccp_mode_t m);
        if (k == 6)
            return (m == PIF_MODE_CAPTURE) ? 8'h20 : 8'h00;
        if (k == 5)
            return (m == PIF_MODE_COMPARE) ? 8'h20 : 8'h00;
        return (k > 6) ? 8'h01 << (k - 1) : 8'h01 << k;
    endfunction
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fire, cause_fire} = '0;
        pstrb = 4'hf;
        ccp_mode = PIF_MODE_OFF;
        v = 8'($urandom(32'h2580));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, PIF_ENABLE_OFF, 0);
        chk(rd, 0);
        apb(0, PIF_POWER_OFF, 0);
        chk(rd, {24'h0, PIF_POWER_RST});
        chk(soft_brownout_enable, 1);
        repeat (4)
        begin
            v = 8'($urandom);
            apb(1, PIF_ENABLE_OFF, {24'h0, v});
            apb(0, PIF_ENABLE_OFF, 0);
            chk(rd, {24'h0, v});
        end
        apb(1, PIF_ENABLE_OFF, 0);
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 9; k++)
            begin
                ccp_mode <= pif_ccp_mode_t'(m);
                pulse(9'h001 << k, 3'h0);
                apb(0, PIF_REQUEST_OFF, 0);
                chk(rd, {24'h0, flag_of(k, pif_ccp_mode_t'(m))});
                apb(1, PIF_REQUEST_OFF, 0);
            end
        for (int n = 0; n < 4; n++)
        begin
            v = 8'h01 << $urandom_range(4, 0);
            apb(1, PIF_CONTROL_OFF, n);
            apb(1, PIF_ENABLE_OFF, {24'h0, v});
            pulse({1'b0, v}, 3'h0);
            chk(periph_irq, n == 3);
            apb(1, PIF_ENABLE_OFF, {24'h0, ~v});
            repeat (2) @(posedge pclk);
            chk(periph_irq, 0);
            apb(1, PIF_REQUEST_OFF, 0);
        end
        // event arrives in the very cycle the clearing write lands
        fork
            apb(1, PIF_REQUEST_OFF, 0);
            begin
                fire <= 9'h001;
                @(posedge pclk);
                fire <= '0;
            end
        join
        apb(0, PIF_REQUEST_OFF, 0);
        chk(rd, {24'h0, flag_of(0, ccp_mode)});
        apb(1, PIF_REQUEST_OFF, 0);
        repeat (3)
        begin
            c = 3'($urandom);
            v = {2'h0, 2'($urandom), 4'hf};
            apb(1, PIF_POWER_OFF, {24'h0, v});
            chk({ulp_wake_enable, soft_brownout_enable}, v[5:4]);
            pulse(9'h0, c);
            apb(0, PIF_POWER_OFF, 0);
            chk(rd, {24'h0, v & ~{4'h0, c[1], c[0], 1'b0, c[2]}});
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, PIF_POWER_OFF, 0);
        chk(rd, {24'h0, PIF_POWER_RST});
        apb(1, 12'h010, 32'hff);
        chk(err, 1);
        apb(0, 12'h010, 0);
        chk({rd[30:0], err}, 1);
        pstrb <= 4'he;
        apb(1, PIF_ENABLE_OFF, 32'hff);
        pstrb <= 4'hf;
        apb(0, PIF_ENABLE_OFF, 0);
        chk(rd, 0);
        end_of_test();
    end
endmodule // tb_pif_top
`default_nettype wire
